// *** src/upb_pkg.sv ***
// Shared constants and types for the upstream pre-equalizer and burst profile block.
// Assumes one clock domain; all users reference items as upb_pkg::name.
// Functional notes
// [RULE1] Eight-tap symbol-spaced linear pre-equalizer from ranging responses.
// [RULE2] Optional 1, 2 or 4 samples per symbol; this block builds only 1 sample per symbol.
// [RULE3] Coefficients are 16-bit s1.14 two's complement.
// [RULE4] New taps convolve received with current taps.
// [RULE5] Headend sends eight symbol-spaced taps before registration.
// [RULE6] Headend may send fractional spacing after registration.
// [RULE7] Frequency or rate change restores unit first tap.
// [RULE8] Initial ranging: modem compensates main tap delay.
// [RULE9] Headend keeps main tap fixed during maintenance.
// [RULE10] Scale taps so datapath never overflows.
// [RULE11] Offset transmit power for new tap gain.
// [RULE12] Equal counts keep main tap; else compensate offset.
// [RULE13] Accept up to 64 four-byte complex coefficients.
// [RULE14] Profile: QPSK/16QAM, diff enc, preamble length, offset.
// [RULE15] Profile: FEC T 0..10, k 16..253, last codeword.
// [RULE16] Profile: 15-bit seed, scrambler enable, guard 5..255.
// [RULE17] Max burst 0..255 minislots; zero means grant length.
// [RULE18] Ranging offset 16 bits in 6.25us/64 units.
// [RULE19] Negative adjustment decreases offset, transmits later.
// [RULE20] One-symbol resolution; accurate minislot burst timing.
// [RULE21] Bursts start at granted minislot times.
// [RULE22] Profile switches back to back unless reconfiguration.
// [RULE23] Complex FIR, one output per sample.
package upb_pkg;
	localparam int NTAPS = 8;
	localparam int SPS_DEFAULT = 1;
	localparam int MAX_RX_COEF = 64;
	localparam int FIFO_DEPTH = 8;
	localparam int FRAC_BITS = 14;
	localparam logic [15:0] COEF_ONE = 16'h4000;
	localparam logic [10:0] PRE_LEN_MAX = 11'h400;
	localparam logic [9:0] PRE_OFF_MAX = 10'h3fe;
	localparam logic [3:0] FEC_T_MAX = 4'ha;
	localparam logic [7:0] FEC_K_MIN = 8'h10;
	localparam logic [7:0] FEC_K_MAX = 8'hfd;
	localparam logic [7:0] GUARD_MIN = 8'h05;
	// Rate codes 0..4 are 160 to 2560 ksym/s; 64 offset units per symbol at code 0
	localparam logic [2:0] RATE_MAX = 3'h4;
	localparam logic [2:0] UNIT_SHIFT_BASE = 3'h6;
	// Unity energy of a s1.14 tap set sits at bit 28 of the square sum
	localparam int ENERGY_UNITY_MSB = 28;
	localparam int DB_PER_OCTAVE = 3;

	typedef struct packed {
		logic mod_qam16;
		logic diff_enc;
		logic [10:0] pre_len;
		logic [9:0] pre_off;
		logic [3:0] fec_t;
		logic [7:0] fec_k;
		logic short_last;
		logic [14:0] scr_seed;
		logic scr_en;
		logic [7:0] max_len;
		logic [7:0] guard;
	} upb_prof_t;

	typedef enum logic [1:0] {C_IDLE, C_CONV, C_NORM, C_COMMIT} upb_coef_st_t;
	typedef enum logic {B_IDLE, B_TX} upb_burst_st_t;
endpackage : upb_pkg

// *** src/upb_stream_if.sv ***
// Valid/ready word stream between the block's own modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
`default_nettype none
interface upb_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : upb_stream_if
`default_nettype wire

// *** src/upb_cmac.sv ***
// Complex multiplier of two s1.14 values, full-precision s4.28 result.
// Assumes signed operands; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module upb_cmac (
	// Operands
	input wire logic [15:0] a_re,
	input wire logic [15:0] a_im,
	input wire logic [15:0] b_re,
	input wire logic [15:0] b_im,
	// Product
	output logic [32:0] p_re,
	output logic [32:0] p_im
);
	logic signed [31:0] rr, ii, ri, ir;
	assign rr = signed'(a_re) * signed'(b_re);
	assign ii = signed'(a_im) * signed'(b_im);
	assign ri = signed'(a_re) * signed'(b_im);
	assign ir = signed'(a_im) * signed'(b_re);
	assign p_re = 33'(rr) - 33'(ii);
	assign p_im = 33'(ri) + 33'(ir);
endmodule : upb_cmac
`default_nettype wire

// *** src/upb_fifo.sv ***
// Sample FIFO with parameter width and depth, valid/ready on both sides.
// Assumes depth is a power of two; storage is flip-flops.
`timescale 1ns/1ps
`default_nettype none
module upb_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill and drain sides
	upb_stream_if.snk wr,
	upb_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("upb_fifo depth must be a power of two of at least 2");
	end
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} upb_fifo_state_t;
	upb_fifo_state_t s, next_s;
	logic push, pop;

	assign wr.ready = s.cnt != (AW+1)'(DEPTH);
	assign rd.valid = s.cnt != '0;
	assign rd.data = s.mem[s.rp];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = wr.data;
			next_s.wp = s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : upb_fifo
`default_nettype wire

// *** src/upb_top.sv ***
// Upstream pre-equalizer with coefficient update engine, profile store and burst scheduler.
// Assumes all inputs come from logic on clk; time_now is the locked upstream time base.
`timescale 1ns/1ps
`default_nettype none
module upb_top #(
	parameter int NTAPS = upb_pkg::NTAPS,
	parameter int SPS = upb_pkg::SPS_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Symbol stream in
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [15:0] in_i,
	input wire logic [15:0] in_q,
	// Equalized stream out
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_i,
	output logic [15:0] out_q,
	// Coefficients of a ranging_response_msg
	input wire logic coef_valid,
	output logic coef_ready,
	input wire logic [5:0] coef_idx,
	input wire logic [6:0] coef_count,
	input wire logic [5:0] coef_main,
	input wire logic coef_last,
	input wire logic [15:0] coef_re,
	input wire logic [15:0] coef_im,
	input wire logic init_ranging,
	output logic [3:0] norm_shift,
	output logic [7:0] power_comp_db,
	// Channel and ranging
	input wire logic [2:0] sym_rate,
	input wire logic [15:0] chan_id,
	input wire logic eq_default,
	input wire logic rng_adj_valid,
	input wire logic [23:0] rng_adj,
	output logic [15:0] ranging_offset,
	// Burst profiles
	input wire logic prof_wr,
	input wire logic [1:0] prof_idx,
	input wire upb_pkg::upb_prof_t prof_data,
	output logic prof_err,
	// Grants and bursts
	input wire logic [31:0] time_now,
	input wire logic [15:0] minislot_units,
	input wire logic power_change,
	input wire logic grant_valid,
	output logic grant_ready,
	input wire logic [31:0] grant_start,
	input wire logic [7:0] grant_len,
	input wire logic [1:0] grant_prof,
	output logic grant_err,
	output logic burst_active,
	output logic burst_start,
	output logic burst_reconfig,
	output logic [7:0] burst_len,
	output upb_pkg::upb_prof_t burst_prof
);
	localparam int IW = $clog2(NTAPS);
	localparam int HALF = NTAPS / 2;

	if (NTAPS < 8 || NTAPS > upb_pkg::MAX_RX_COEF || (1 << IW) != NTAPS) begin : g_bad_taps
		$error("upb_top tap count must be a power of two from 8 to 64");
	end
	if (SPS != 1) begin : g_bad_sps // RULE2
		$error("upb_top supports only symbol-spaced operation");
	end

	typedef logic [NTAPS-1:0][15:0] upb_taps_t;
	typedef struct packed {
		upb_taps_t cur_re;
		upb_taps_t cur_im;
		upb_taps_t rx_re;
		upb_taps_t rx_im;
		upb_taps_t nw_re;
		upb_taps_t nw_im;
		upb_taps_t dl_re;
		upb_taps_t dl_im;
		logic [35:0] acc_re;
		logic [35:0] acc_im;
		logic [IW-1:0] n;
		logic [IW-1:0] k;
		upb_pkg::upb_coef_st_t cst;
		logic [5:0] ws;
		logic [5:0] prev_ws;
		logic [5:0] rx_main;
		logic rx_init;
		logic [3:0] nsh;
		logic [7:0] pdb;
		logic [15:0] rng;
		logic [2:0] last_rate;
		logic [15:0] last_chan;
		logic rate_chg;
		upb_pkg::upb_prof_t [3:0] profs;
		logic pend_v;
		logic [31:0] pend_start;
		logic [7:0] pend_len;
		logic [1:0] pend_prof;
		upb_pkg::upb_burst_st_t bst;
		logic [31:0] bend;
		logic [7:0] blen;
		upb_pkg::upb_prof_t bprof;
		logic bstart;
		logic brecfg;
		logic last_mod;
		logic [15:0] rng_last;
		logic perr;
		logic gerr;
		logic ov;
		logic [15:0] oi;
		logic [15:0] oq;
	} upb_top_state_t;
	upb_top_state_t s, next_s;

	// s7.28 accumulator back to s1.14 with saturation
	function automatic logic [15:0] upb_sat(input logic [35:0] v);
		logic [21:0] t;
		t = v[35:upb_pkg::FRAC_BITS];
		if (t[21:15] == {7{t[21]}}) begin
			return t[15:0];
		end
		return t[21] ? 16'h8000 : 16'h7fff;
	endfunction : upb_sat

	function automatic logic [35:0] upb_sum(input logic [NTAPS-1:0][32:0] p);
		logic [35:0] a;
		a = '0;
		for (int i = 0; i < NTAPS; i++) begin
			a = a + 36'(signed'(p[i]));
		end
		return a;
	endfunction : upb_sum

	// Worst-case gain of a tap set: sum of absolute real and imaginary parts
	function automatic logic [21:0] upb_l1(input upb_taps_t re, input upb_taps_t im);
		logic [21:0] a;
		logic signed [16:0] r, q;
		a = '0;
		r = '0;
		q = '0;
		for (int i = 0; i < NTAPS; i++) begin
			r = 17'(signed'(re[i]));
			q = 17'(signed'(im[i]));
			a = a + 22'(r[16] ? -r : r) + 22'(q[16] ? -q : q);
		end
		return a;
	endfunction : upb_l1

	// Power gain in dB, about 3 dB per octave of tap energy
	function automatic logic [7:0] upb_gain_db(input upb_taps_t re, input upb_taps_t im);
		logic [35:0] e;
		int m;
		e = '0;
		m = 0;
		for (int i = 0; i < NTAPS; i++) begin
			e = e + 36'(signed'(re[i]) * signed'(re[i])) + 36'(signed'(im[i]) * signed'(im[i]));
		end
		for (int b = 0; b < 36; b++) begin
			if (e[b]) begin
				m = b;
			end
		end
		return 8'(upb_pkg::DB_PER_OCTAVE * (m - upb_pkg::ENERGY_UNITY_MSB));
	endfunction : upb_gain_db

	function automatic logic [15:0] upb_rng_add(input logic [15:0] off, input logic [31:0] d);
		logic [31:0] t;
		t = {16'h0000, off} + d;
		if (t[31]) begin
			return 16'h0000;
		end
		return (t[30:16] != '0) ? 16'hffff : t[15:0];
	endfunction : upb_rng_add

	// Sample FIFO ahead of the filter
	upb_stream_if #(.W(32)) f_in();
	upb_stream_if #(.W(32)) f_out();
	assign f_in.valid = in_valid;
	assign f_in.data = {in_i, in_q};
	assign in_ready = f_in.ready;
	upb_fifo #(.W(32), .DEPTH(upb_pkg::FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.wr(f_in.snk),
		.rd(f_out.src)
	);

	// Filter taps on the shifted delay line including the incoming sample
	upb_taps_t tin_re, tin_im;
	logic [NTAPS-1:0][32:0] fp_re, fp_im;
	logic [35:0] fir_re, fir_im;
	logic fir_adv;
	for (genvar t = 0; t < NTAPS; t++) begin : g_tap
		if (t == 0) begin : g_head
			assign tin_re[t] = f_out.data[31:16];
			assign tin_im[t] = f_out.data[15:0];
		end else begin : g_line
			assign tin_re[t] = s.dl_re[t-1];
			assign tin_im[t] = s.dl_im[t-1];
		end
		upb_cmac u_mac (
			.a_re(s.cur_re[t]),
			.a_im(s.cur_im[t]),
			.b_re(tin_re[t]),
			.b_im(tin_im[t]),
			.p_re(fp_re[t]),
			.p_im(fp_im[t])
		);
	end
	assign fir_re = upb_sum(fp_re);
	assign fir_im = upb_sum(fp_im);
	assign f_out.ready = !s.ov || out_ready;
	assign fir_adv = f_out.valid && f_out.ready;

	// Convolution term rx[k] * cur[n-k]
	logic [32:0] cp_re, cp_im;
	logic [35:0] conv_re, conv_im;
	upb_cmac u_conv (
		.a_re(s.rx_re[s.k]),
		.a_im(s.rx_im[s.k]),
		.b_re(s.cur_re[s.n - s.k]),
		.b_im(s.cur_im[s.n - s.k]),
		.p_re(cp_re),
		.p_im(cp_im)
	);
	assign conv_re = s.acc_re + 36'(signed'(cp_re));
	assign conv_im = s.acc_im + 36'(signed'(cp_im));

	// Window of received taps kept by this equalizer
	logic [5:0] ws_c, rx_pos;
	logic rx_hit;
	always_comb begin
		ws_c = 6'h00;
		if (coef_count != 7'(NTAPS) && coef_main > 6'(HALF)) begin
			ws_c = coef_main - 6'(HALF);
		end
		if (coef_count > 7'(NTAPS) && 7'(ws_c) > coef_count - 7'(NTAPS)) begin
			ws_c = 6'(coef_count - 7'(NTAPS));
		end
	end
	assign rx_pos = coef_idx - ws_c;
	assign rx_hit = coef_idx >= ws_c && rx_pos < 6'(NTAPS)
		&& coef_count <= 7'(upb_pkg::MAX_RX_COEF);

	// Offset units per symbol and symbol-aligned time compare
	logic [2:0] rate_c, ush;
	logic [31:0] qmask, ahead, dt_go, dt_end, coef_d, rng_d;
	logic [7:0] dsym;
	logic go, done, commit, chg;
	assign rate_c = (sym_rate > upb_pkg::RATE_MAX) ? upb_pkg::RATE_MAX : sym_rate;
	assign ush = upb_pkg::UNIT_SHIFT_BASE - rate_c;
	assign qmask = ~((32'h0000_0001 << ush) - 32'h0000_0001);
	assign ahead = time_now + {16'h0000, s.rng};
	assign dt_go = (ahead & qmask) - (s.pend_start & qmask);
	assign dt_end = (ahead & qmask) - (s.bend & qmask);
	assign go = s.pend_v && !dt_go[31];
	assign done = !dt_end[31];
	assign commit = s.cst == upb_pkg::C_COMMIT;
	assign dsym = s.rx_init ? {2'b00, s.rx_main - s.ws} : {2'b00, s.prev_ws} - {2'b00, s.ws};
	assign coef_d = 32'(signed'(dsym)) << ush;
	assign rng_d = (rng_adj_valid ? 32'(signed'(rng_adj)) : 32'h0) + (commit ? coef_d : 32'h0);
	assign chg = eq_default || sym_rate != s.last_rate || chan_id != s.last_chan;

	// Profile and grant checks
	upb_pkg::upb_prof_t gp;
	logic pbad, gbad;
	logic [7:0] glen;
	assign pbad = prof_data.pre_len > upb_pkg::PRE_LEN_MAX
		|| (prof_data.mod_qam16 ? prof_data.pre_len[1:0] != 2'h0 : prof_data.pre_len[0])
		|| prof_data.pre_off > upb_pkg::PRE_OFF_MAX
		|| prof_data.fec_t > upb_pkg::FEC_T_MAX
		|| (prof_data.fec_t != 4'h0 && (prof_data.fec_k < upb_pkg::FEC_K_MIN
		|| prof_data.fec_k > upb_pkg::FEC_K_MAX))
		|| prof_data.guard < upb_pkg::GUARD_MIN;
	assign gp = s.profs[grant_prof];
	assign gbad = gp.max_len == 8'h00 && grant_len == 8'h00;
	assign glen = (gp.max_len == 8'h00) ? grant_len
		: ((grant_len == 8'h00 || grant_len > gp.max_len) ? gp.max_len : grant_len);

	always_comb begin
		next_s = s;
		next_s.bstart = 1'b0;
		next_s.perr = 1'b0;
		next_s.gerr = 1'b0;
		// Filter: one output per accepted sample
		if (fir_adv) begin
			next_s.dl_re = tin_re;
			next_s.dl_im = tin_im;
			next_s.ov = 1'b1;
			next_s.oi = upb_sat(fir_re); // RULE23
			next_s.oq = upb_sat(fir_im); // RULE10
		end else if (out_ready) begin
			next_s.ov = 1'b0;
		end
		case (s.cst)
			upb_pkg::C_IDLE: begin
				if (coef_valid) begin
					if (rx_hit) begin
						next_s.rx_re[rx_pos[IW-1:0]] = coef_re; // RULE13
						next_s.rx_im[rx_pos[IW-1:0]] = coef_im; // RULE3
					end
					next_s.ws = ws_c; // RULE12
					next_s.rx_main = coef_main;
					next_s.rx_init = init_ranging;
					if (coef_last) begin
						next_s.cst = upb_pkg::C_CONV;
						next_s.n = '0;
						next_s.k = '0;
						next_s.acc_re = '0;
						next_s.acc_im = '0;
						next_s.nsh = 4'h0;
					end
				end
			end
			upb_pkg::C_CONV: begin
				if (s.k == s.n) begin
					next_s.nw_re[s.n] = upb_sat(conv_re); // RULE4
					next_s.nw_im[s.n] = upb_sat(conv_im);
					next_s.acc_re = '0;
					next_s.acc_im = '0;
					next_s.k = '0;
					next_s.n = s.n + 1'b1;
					if (s.n == IW'(NTAPS - 1)) begin
						next_s.cst = upb_pkg::C_NORM;
					end
				end else begin
					next_s.acc_re = conv_re;
					next_s.acc_im = conv_im;
					next_s.k = s.k + 1'b1;
				end
			end
			upb_pkg::C_NORM: begin
				// Halve until worst-case gain is unity so the filter cannot clip
				if (upb_l1(s.nw_re, s.nw_im) > 22'(upb_pkg::COEF_ONE)) begin
					for (int i = 0; i < NTAPS; i++) begin
						next_s.nw_re[i] = {s.nw_re[i][15], s.nw_re[i][15:1]}; // RULE10
						next_s.nw_im[i] = {s.nw_im[i][15], s.nw_im[i][15:1]};
					end
					if (s.nsh != 4'hf) begin
						next_s.nsh = s.nsh + 4'h1;
					end
				end else begin
					next_s.cst = upb_pkg::C_COMMIT;
				end
			end
			upb_pkg::C_COMMIT: begin
				next_s.cur_re = s.nw_re;
				next_s.cur_im = s.nw_im;
				next_s.rx_re = '0;
				next_s.rx_im = '0;
				next_s.pdb = 8'h00 - upb_gain_db(s.nw_re, s.nw_im); // RULE11
				next_s.prev_ws = s.ws; // RULE8
				next_s.cst = upb_pkg::C_IDLE;
			end
			default: begin
				next_s.cst = upb_pkg::C_IDLE;
			end
		endcase
		if (rng_adj_valid || commit) begin
			next_s.rng = upb_rng_add(s.rng, rng_d); // RULE18 RULE19 RULE8 RULE12
		end
		// Default tap set wins over any update in progress
		if (chg) begin
			next_s.cur_re = '0; // RULE7
			next_s.cur_im = '0;
			next_s.cur_re[0] = upb_pkg::COEF_ONE; // RULE1
			next_s.rx_re = '0;
			next_s.rx_im = '0;
			next_s.cst = upb_pkg::C_IDLE;
			next_s.nsh = 4'h0;
			next_s.pdb = 8'h00;
			next_s.prev_ws = 6'h00;
		end
		next_s.last_rate = sym_rate;
		next_s.last_chan = chan_id;
		if (prof_wr) begin
			if (pbad) begin
				next_s.perr = 1'b1;
			end else begin
				next_s.profs[prof_idx] = prof_data; // RULE14 RULE15 RULE16
			end
		end
		if (grant_valid && !s.pend_v) begin
			if (gbad) begin
				next_s.gerr = 1'b1;
			end else begin
				next_s.pend_v = 1'b1;
				next_s.pend_start = grant_start;
				next_s.pend_len = glen; // RULE17
				next_s.pend_prof = grant_prof;
			end
		end
		case (s.bst)
			upb_pkg::B_IDLE: begin
				if (go) begin
					next_s.bst = upb_pkg::B_TX;
				end
			end
			upb_pkg::B_TX: begin
				if (!go && done) begin
					next_s.bst = upb_pkg::B_IDLE;
				end
			end
			default: begin
				next_s.bst = upb_pkg::B_IDLE;
			end
		endcase
		// Launch at the symbol holding the granted time, even mid-burst
		if (go) begin
			next_s.pend_v = 1'b0; // RULE21 RULE20
			next_s.bstart = 1'b1; // RULE22
			next_s.bend = s.pend_start + {8'h00, 24'(s.pend_len) * 24'(minislot_units)};
			next_s.blen = s.pend_len;
			next_s.bprof = s.profs[s.pend_prof];
			next_s.brecfg = s.rate_chg || power_change || s.rng != s.rng_last
				|| s.profs[s.pend_prof].mod_qam16 != s.last_mod; // RULE22
			next_s.last_mod = s.profs[s.pend_prof].mod_qam16;
			next_s.rng_last = s.rng;
			next_s.rate_chg = 1'b0;
		end
		if (sym_rate != s.last_rate) begin
			next_s.rate_chg = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.cur_re[0] <= upb_pkg::COEF_ONE;
		end else begin
			s <= next_s;
		end
	end

	assign out_valid = s.ov;
	assign out_i = s.oi;
	assign out_q = s.oq;
	assign coef_ready = s.cst == upb_pkg::C_IDLE;
	assign norm_shift = s.nsh;
	assign power_comp_db = s.pdb;
	assign ranging_offset = s.rng;
	assign prof_err = s.perr;
	assign grant_ready = !s.pend_v;
	assign grant_err = s.gerr;
	assign burst_active = s.bst == upb_pkg::B_TX;
	assign burst_start = s.bstart;
	assign burst_reconfig = s.brecfg;
	assign burst_len = s.blen;
	assign burst_prof = s.bprof;
endmodule : upb_top
`default_nettype wire

// *** dv/upb_sva.sv ***
// Concurrent checks on the ports of the pre-equalizer and burst block.
// Assumes one clock domain; attached to upb_top by the bind below.
`timescale 1ns/1ps
`default_nettype none
module upb_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [15:0] out_i,
	input wire logic [15:0] out_q,
	input wire logic coef_valid,
	input wire logic coef_ready,
	input wire logic coef_last,
	input wire logic prof_wr,
	input wire upb_pkg::upb_prof_t prof_data,
	input wire logic prof_err,
	input wire logic burst_start,
	input wire logic burst_active,
	input wire logic [7:0] burst_len
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_out_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("stalled sample lost");
	property p_start_pulse;
		burst_start |=> !burst_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
	property p_start_act;
		burst_start |-> burst_active;
	endproperty
	a_start_act: assert property (p_start_act) else $error("start without burst");
	property p_len_nz;
		burst_start |-> burst_len != 8'h00;
	endproperty
	a_len_nz: assert property (p_len_nz) else $error("burst of zero length");
	property p_coef_busy;
		coef_valid && coef_ready && coef_last |=> !coef_ready [*8];
	endproperty
	a_coef_busy: assert property (p_coef_busy) else $error("update ended early");
	property p_coef_done;
		coef_valid && coef_ready && coef_last |-> ##[38:90] coef_ready;
	endproperty
	a_coef_done: assert property (p_coef_done) else $error("update never ended");
	property p_fec_bad;
		prof_wr && prof_data.fec_t > upb_pkg::FEC_T_MAX |=> prof_err;
	endproperty
	a_fec_bad: assert property (p_fec_bad) else $error("bad strength kept");
	property p_guard_bad;
		prof_wr && prof_data.guard < upb_pkg::GUARD_MIN |=> prof_err;
	endproperty
	a_guard_bad: assert property (p_guard_bad) else $error("short guard kept");
	property p_prof_ok;
		prof_wr && prof_data.fec_t == 4'h0 && prof_data.guard >= upb_pkg::GUARD_MIN
			&& prof_data.pre_len == 11'h000 && prof_data.pre_off <= upb_pkg::PRE_OFF_MAX
			|=> !prof_err;
	endproperty
	a_prof_ok: assert property (p_prof_ok) else $error("good profile refused");
endmodule : upb_sva
bind upb_top upb_sva i_sva (.clk, .rst, .out_valid, .out_ready, .out_i, .out_q, .coef_valid,
	.coef_ready, .coef_last, .prof_wr, .prof_data, .prof_err, .burst_start, .burst_active,
	.burst_len);
`default_nettype wire

// *** dv/upb_headend.sv ***
// Headend model that sends coefficient sets of ranging responses.
// Assumes the bench calls send and drives every other port itself.
`timescale 1ns/1ps
`default_nettype none
module upb_headend (
	// Clock
	input wire logic clk,
	// Coefficient words
	output logic coef_valid,
	input wire logic coef_ready,
	output logic [5:0] coef_idx,
	output logic [6:0] coef_count,
	output logic [5:0] coef_main,
	output logic coef_last,
	output logic [15:0] coef_re,
	output logic [15:0] coef_im,
	output logic init_ranging
);
	initial begin
		coef_valid = 1'b0;
		coef_idx = 6'h00;
		coef_count = 7'h08;
		coef_main = 6'h00;
		coef_last = 1'b0;
		coef_re = 16'h0000;
		coef_im = 16'h0000;
		init_ranging = 1'b0;
	end
	// Main tap carries a, the next tap b, the rest zero
	task automatic send(input logic [6:0] n, input logic [5:0] m, input logic r,
		input logic [15:0] a, input logic [15:0] b);
		for (int i = 0; i < n; i++) begin
			coef_valid = 1'b1;
			coef_idx = i[5:0];
			coef_count = n;
			coef_main = m;
			init_ranging = r;
			coef_re = (i == m) ? a : ((i == m + 1) ? b : 16'h0000);
			coef_im = 16'h0000;
			coef_last = (i == n - 1);
			while (coef_ready !== 1'b1) @(posedge clk) #1;
			@(posedge clk) #1;
		end
		coef_valid = 1'b0;
		coef_last = 1'b0;
		coef_re = ~coef_re;
	endtask : send
endmodule : upb_headend
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the upstream pre-equalizer and burst profile block.
// Assumes the headend model drives coefficients; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [15:0] zz = 16'h0000;
	logic clk, rst = 1'b1, in_valid = 1'b0, out_ready = 1'b1, eq_default = 1'b0;
	logic rng_adj_valid = 1'b0, prof_wr = 1'b0, grant_valid = 1'b0, power_change = 1'b0;
	logic [15:0] in_i = zz, in_q = zz, chan_id = zz, minislot_units = 16'h0010;
	logic [2:0] sym_rate = 3'h4;
	logic [23:0] rng_adj = 24'h000000;
	logic [1:0] prof_idx = 2'h0, grant_prof = 2'h0;
	logic [31:0] time_now = 32'h0, grant_start = 32'h0, t0, outs [$];
	logic [7:0] grant_len = 8'h00, power_comp_db, burst_len;
	upb_pkg::upb_prof_t prof_data = '0, burst_prof, tbl [8];
	logic in_ready, out_valid, coef_valid, coef_ready, coef_last, init_ranging, prof_err;
	logic grant_ready, grant_err, burst_active, burst_start, burst_reconfig;
	logic [15:0] out_i, out_q, coef_re, coef_im, ranging_offset;
	logic [5:0] coef_idx, coef_main;
	logic [6:0] coef_count;
	logic [3:0] norm_shift;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	upb_top i_dut (.clk, .rst, .in_valid, .in_ready, .in_i, .in_q, .out_valid, .out_ready,
		.out_i, .out_q, .coef_valid, .coef_ready, .coef_idx, .coef_count, .coef_main,
		.coef_last, .coef_re, .coef_im, .init_ranging, .norm_shift, .power_comp_db,
		.sym_rate, .chan_id, .eq_default, .rng_adj_valid, .rng_adj, .ranging_offset,
		.prof_wr, .prof_idx, .prof_data, .prof_err, .time_now, .minislot_units,
		.power_change, .grant_valid, .grant_ready, .grant_start, .grant_len, .grant_prof,
		.grant_err, .burst_active, .burst_start, .burst_reconfig, .burst_len, .burst_prof);
	upb_headend i_hdend (.clk, .coef_valid, .coef_ready, .coef_idx, .coef_count,
		.coef_main, .coef_last, .coef_re, .coef_im, .init_ranging);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) time_now <= #1 time_now + 32'h1;
	always @(negedge clk) if (out_valid === 1'b1 && out_ready === 1'b1) outs.push_back({out_q, out_i});
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick
	function automatic upb_pkg::upb_prof_t mk(input logic q, input logic [10:0] pl,
		input logic [9:0] po, input logic [3:0] t, input logic [7:0] k, input logic [7:0] g);
		return '{q, q, pl, po, t, k, q, 15'h2b5c, 1'b1, 8'h03, g};
	endfunction : mk
	// Impulse of one half, then zeros until the stalled path refuses
	task automatic imp(input logic [15:0] e [7]);
		outs.delete();
		out_ready = 1'b0;
		in_valid = 1'b1;
		in_i = 16'h2000;
		for (n = 0; in_ready === 1'b1 && n < 20; n++) begin
			tick(1);
			in_i = zz;
		end
		in_valid = 1'b0;
		chk(n >= upb_pkg::FIFO_DEPTH && n <= upb_pkg::FIFO_DEPTH + 2, 1);
		out_ready = 1'b1;
		tick(n + 4);
		chk(outs.size(), n);
		for (int k = 0; k < 7; k++) chk(outs[k], e[k]);
	endtask : imp
	task automatic set(input logic [6:0] c, input logic [5:0] m, input logic r,
		input logic [15:0] a, input logic [15:0] b);
		i_hdend.send(c, m, r, a, b);
		while (coef_ready !== 1'b1) tick(1);
	endtask : set
	task automatic adj(input logic [23:0] a);
		rng_adj = a;
		rng_adj_valid = 1'b1;
		tick(1);
		rng_adj_valid = 1'b0;
		tick(1);
	endtask : adj
	task automatic grant(input logic [31:0] s, input logic [7:0] l, input logic [1:0] p);
		tick(1);
		grant_start = s;
		grant_len = l;
		grant_prof = p;
		grant_valid = 1'b1;
		while (grant_ready !== 1'b1) tick(1);
		tick(1);
		grant_valid = 1'b0;
	endtask : grant
	task automatic waitb();
		while (burst_start !== 1'b1) tick(1);
	endtask : waitb
	initial begin
		#400us;
		num_errors++;
		test_done();
	end
	initial begin
		tbl[0] = mk(1'b0, 11'h000, 10'h000, 4'h0, 8'h10, 8'h05);
		tbl[1] = mk(1'b0, 11'h400, 10'h3fe, 4'ha, 8'hfd, 8'hff);
		tbl[2] = mk(1'b0, 11'h040, 10'h000, 4'hb, 8'h10, 8'h05);
		tbl[3] = mk(1'b0, 11'h040, 10'h000, 4'h0, 8'h10, 8'h04);
		tbl[4] = mk(1'b0, 11'h402, 10'h000, 4'h0, 8'h10, 8'h05);
		tbl[5] = mk(1'b0, 11'h040, 10'h3ff, 4'h0, 8'h10, 8'h05);
		tbl[6] = mk(1'b0, 11'h040, 10'h000, 4'h1, 8'h0f, 8'h05);
		tbl[7] = mk(1'b1, 11'h006, 10'h000, 4'h0, 8'h10, 8'h05);
		tbl[0].max_len = 8'h00;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		tick(2);
		chk({in_ready, coef_ready, grant_ready}, 3'h7);
		chk(ranging_offset, zz);
		for (int i = 0; i < 8; i++) begin
			tick(1);
			prof_idx = i[1:0];
			prof_data = tbl[i];
			prof_wr = 1'b1;
			tick(1);
			prof_wr = 1'b0;
			chk(prof_err, i > 1);
		end
		imp('{16'h2000, zz, zz, zz, zz, zz, zz});
		set(7'h08, 6'h02, 1'b1, 16'h2000, 16'h1000);
		chk(ranging_offset, 16'h0008);
		chk(norm_shift, 4'h0);
		chk(power_comp_db, 8'h06);
		imp('{zz, zz, 16'h1000, 16'h0800, zz, zz, zz});
		set(7'h08, 6'h02, 1'b0, 16'h4000, 16'h4000);
		chk(norm_shift, 4'h1);
		chk(ranging_offset, 16'h0008);
		imp('{zz, zz, zz, zz, 16'h0800, 16'h0c00, 16'h0400});
		adj(24'h000028);
		adj(24'hfffff6);
		chk(ranging_offset, 16'h0026);
		set(7'h40, 6'h0a, 1'b0, 16'h4000, zz);
		chk(ranging_offset, 16'h000e);
		eq_default = 1'b1;
		tick(1);
		eq_default = 1'b0;
		tick(2);
		imp('{16'h2000, zz, zz, zz, zz, zz, zz});
		grant(32'h0, 8'h00, 2'h0);
		chk(grant_err, 1);
		t0 = {time_now[31:2], 2'b00} + 32'h40;
		grant(t0, 8'h05, 2'h0);
		waitb();
		chk(burst_len, 8'h05);
		chk(time_now + 32'h0e - t0 <= 32'h6, 1);
		grant(t0 + 32'h50, 8'h09, 2'h1);
		waitb();
		chk(burst_len, 8'h03);
		chk(burst_reconfig, 0);
		chk(burst_prof === tbl[1], 1);
		chk(time_now + 32'h0e - t0 - 32'h50 <= 32'h6, 1);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
